// ### egress_stat_map.sv
`timescale 1ns/100ps
// Function
// RL1: Port counter index is egress port number with frame priority, colour as service.
// RL2: Mode 0 service index is classifier base plus class offset when base usable.
// RL3: Mode 0 without usable base uses ingress index, two top bits dropped.
// RL4: Modes 0 and 1 colour comes from drop level through global colour map.
// RL5: Mode 1 as mode 0 but no service counting without egress index.
// RL6: Mode 2 uses ingress index, colour is destination MAC bit 40.
// RL7: Mode 3 uses classified, pushed or routing VID, top two bits dropped.
// RL8: Port counters count transmitted unaborted frames with no extract action, any port.
// RL9: Service counters need physical port, mode match, no abort, no late extract.
// RL10: Extracted or assembly-looped frames count only at or after extract point.
// RL11: Injected or queue-looped frames count only at or before inject point.
// RL12: Abort counter counts queue aborts, rewriter aborts only with enable set.
// RL13: Classifier key carries the protection active flag.
// RL14: Protection select with flag active swaps encap, service base, endpoint index.
// RL15: Two mapping resources of 2,048 entries each hold all mapped fields.
// RL16: Two lookups per resource give mapping tables 0 to 3.
// RL17: Table address is action base in upper bits plus selected key bits.
// RL18: Key code 2 uses DSCP and is invalid for non IP frames.
// RL19: Table 1 falls back to table 0 then fixed value; 3 to 2 likewise.
// RL20: Tables 0 and 1 use resource A, tables 2 and 3 resource B.
// RL21: Each index counts frames in 32 bits and octets in 40 bits.
// RL22: All four results with validity are delivered for every frame.
module egress_stat_map
   import egress_stat_pkg::*;
#(
   parameter int NUM_PORTS = 16,
   parameter int NUM_PHYS = 11,
   parameter int MAP_DEPTH = 2048
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Frame and classifier action
   input wire logic frame_valid,
   input wire frame_s frame,
   input wire action_s cls,
   // Configuration
   input wire logic [1:0] stat_mode,
   input wire logic [3:0] drop_level_colour_map,
   input wire logic abort_count_enable,
   input wire logic [NUM_PORTS-1:0][PT_W-1:0] extract_count_point,
   input wire logic [NUM_PORTS-1:0][PT_W-1:0] inject_count_point,
   // Mapping resource writes
   input wire logic map_wr,
   input wire logic map_wr_res_b,
   input wire logic [MAP_AW-1:0] map_wr_addr,
   input wire map_entry_s map_wr_data,
   // Counter read back
   input wire logic cnt_rd,
   input wire logic [1:0] cnt_rd_kind,
   input wire logic [IDX_W:0] cnt_rd_addr,
   output logic cnt_rd_valid,
   output logic [FRM_W-1:0] cnt_rd_frames,
   output logic [OCT_W-1:0] cnt_rd_octets,
   // Per frame results
   output logic class_key_prot,
   output logic res_valid,
   output logic [IDX_W-1:0] svc_index,
   output logic svc_colour,
   output logic svc_update,
   output logic [PORT_W+PRIO_W-1:0] port_index,
   output logic port_update,
   output logic abort_update,
   output logic [ID_W-1:0] encapsulation_id,
   output logic [ID_W-1:0] oam_endpoint_index,
   output map_result_s [NUM_MAP-1:0] map_result,
   output map_entry_s map_sel_a,
   output map_entry_s map_sel_b
);
   localparam int SVC_N = 2 ** (IDX_W + 1);
   localparam int PC_N = NUM_PORTS * 2 ** (PRIO_W + 1);

   state_s st_reg, st_next;
   map_entry_s res_a [MAP_DEPTH];
   map_entry_s res_b [MAP_DEPTH];
   map_entry_s rd_reg [NUM_MAP];
   logic [FRM_W-1:0] svc_frm [SVC_N];
   logic [OCT_W-1:0] svc_oct [SVC_N];
   logic [FRM_W-1:0] pc_frm [PC_N];
   logic [OCT_W-1:0] pc_oct [PC_N];
   logic [FRM_W-1:0] ab_frm [NUM_PORTS];
   logic [OCT_W-1:0] ab_oct [NUM_PORTS];
   logic [MAP_AW-1:0] map_addr [NUM_MAP];
   logic rd_v_reg;
   logic [FRM_W-1:0] rd_f_reg;
   logic [OCT_W-1:0] rd_o_reg;

   function automatic logic [MAP_KEY_W:0] key_lsb(input logic [3:0] sel, input frame_s f);
      logic [MAP_KEY_W:0] k;
      k = '0;
      case (sel)
         KEY_PCP_DEI: k = {1'b1, 2'h0, f.dei, f.pcp};
         KEY_DP_COS: k = {1'b1, 1'b0, f.dp, f.cosid};
         KEY_DSCP: k = {f.is_ip, f.dscp}; // RL18
         KEY_TC: k = {f.is_mpls, 3'h0, f.tc};
         KEY_COS: k = {1'b1, 3'h0, f.cosid};
         default: k = '0;
      endcase
      return k;
   endfunction

   function automatic logic is_extract(input logic [2:0] a);
      return a == ACT_EXTRACT || a == ACT_UP_EXTRACT || a == ACT_LBK_ASSEMBLY;
   endfunction

   function automatic logic is_inject(input logic [2:0] a);
      return a == ACT_INJECT || a == ACT_INJECT_X || a == ACT_QUEUE_LBK;
   endfunction

   // Table address for each lookup
   always_comb begin
      logic [MAP_KEY_W:0] k;
      k = '0;
      for (int i = 0; i < NUM_MAP; i++) begin
         k = key_lsb(cls.map_key[i], frame);
         // Wide base shifted up by three bits, key added into the lower bits
         map_addr[i] = MAP_AW'({cls.map_table_base[i], MAP_BASE_SHIFT'(0)}
            + MAP_AW'(k[MAP_KEY_W-1:0])); // RL17
      end
   end

   always_comb begin
      stat_s s;
      logic [IDX_W-1:0] base;
      logic egress_service_index_ok;
      logic mode_ok;
      logic pt_ok;
      logic [MAP_KEY_W:0] k;
      logic [PT_W-1:0] xpt;
      logic [PT_W-1:0] ipt;
      st_next = st_reg;
      s = '0;
      k = '0;
      xpt = extract_count_point[frame.port];
      ipt = inject_count_point[frame.port];
      base = (cls.prot_sel && frame.protection_active_flag) ?
         cls.service_counter_base_p : cls.service_counter_base; // RL14
      egress_service_index_ok = cls.lookup_en && base != '0;
      s.valid = frame_valid;
      s.encap = (cls.prot_sel && frame.protection_active_flag) ?
         cls.encapsulation_id_p : cls.encapsulation_id; // RL14
      s.oam = (cls.prot_sel && frame.protection_active_flag) ?
         cls.oam_endpoint_index_p : cls.oam_endpoint_index; // RL14
      s.prot = frame.protection_active_flag; // RL13
      s.port = frame.port; // RL1
      s.prio = frame.prio; // RL1
      s.len = frame.len;
      s.fixed = cls.fixed;
      for (int i = 0; i < NUM_MAP; i++) begin
         k = key_lsb(cls.map_key[i], frame);
         s.kv[i] = k[MAP_KEY_W];
      end
      mode_ok = 1'b1;
      case (stat_mode)
         MODE_SVC, MODE_SVC_ONLY: begin
            if (egress_service_index_ok) begin
               s.svc_idx = base + IDX_W'(cls.service_class_offset[frame.cosid]); // RL2
            end else begin
               s.svc_idx = frame.ingress_service_index[IDX_W-1:0]; // RL3
            end
            mode_ok = egress_service_index_ok || stat_mode == MODE_SVC; // RL5
            s.svc_col = drop_level_colour_map[frame.dp]; // RL4
         end
         MODE_INGRESS: begin
            s.svc_idx = frame.ingress_service_index[IDX_W-1:0]; // RL6
            s.svc_col = frame.dmac[DMAC_MC_BIT]; // RL6
         end
         default: begin
            if (frame.routed) begin
               s.svc_idx = IDX_W'(frame.routing_leg_egress_vid[VID_KEEP-1:0]); // RL7
            end else if (frame.pushed) begin
               s.svc_idx = IDX_W'(frame.push_vid[VID_KEEP-1:0]); // RL7
            end else begin
               s.svc_idx = IDX_W'(frame.class_vid[VID_KEEP-1:0]); // RL7
            end
            s.svc_col = frame.dmac[DMAC_MC_BIT];
         end
      endcase
      pt_ok = 1'b1;
      if (is_extract(frame.act)) begin
         pt_ok = frame.pt >= xpt; // RL10
      end else if (is_inject(frame.act)) begin
         pt_ok = frame.pt <= ipt; // RL11
      end
      // Port counters also count virtual and CPU ports
      s.port_upd = frame_valid && !frame.abort && !is_extract(frame.act)
         && frame.act != ACT_LATE_EXTRACT; // RL8
      s.svc_upd = frame_valid && 32'(frame.port) < NUM_PHYS && mode_ok && !frame.abort
         && frame.act != ACT_LATE_EXTRACT && pt_ok; // RL9
      s.abort_upd = frame_valid && frame.abort
         && (frame.abort_by_queue || abort_count_enable); // RL12
      st_next.p1 = s;
      st_next.o = st_reg.p1;
      for (int i = 0; i < NUM_MAP; i++) begin
         st_next.res[i] = {st_reg.p1.kv[i], rd_reg[i]}; // RL22
      end
      for (int j = 0; j < 2; j++) begin
         if (st_reg.p1.kv[2*j+1]) begin
            st_next.sel[j] = rd_reg[2*j+1]; // RL19
         end else if (st_reg.p1.kv[2*j]) begin
            st_next.sel[j] = rd_reg[2*j]; // RL19
         end else begin
            st_next.sel[j] = st_reg.p1.fixed; // RL19
         end
      end
      if (sys_rst) begin
         st_next = '0;
      end
   end

   always_ff @(posedge clk_sys) begin
      st_reg <= st_next;
   end

   // Mapping resources: one write port, two read ports each
   always_ff @(posedge clk_sys) begin
      if (map_wr && !map_wr_res_b) begin
         res_a[map_wr_addr] <= map_wr_data; // RL15
      end
      if (map_wr && map_wr_res_b) begin
         res_b[map_wr_addr] <= map_wr_data; // RL15
      end
      rd_reg[0] <= res_a[map_addr[0]]; // RL16 RL20
      rd_reg[1] <= res_a[map_addr[1]]; // RL20
      rd_reg[2] <= res_b[map_addr[2]]; // RL20
      rd_reg[3] <= res_b[map_addr[3]]; // RL20
   end

   // Counters are memories and are not cleared by reset
   always_ff @(posedge clk_sys) begin
      if (st_reg.p1.svc_upd) begin
         svc_frm[{st_reg.p1.svc_col, st_reg.p1.svc_idx}] <=
            svc_frm[{st_reg.p1.svc_col, st_reg.p1.svc_idx}] + FRM_W'(1); // RL21
         svc_oct[{st_reg.p1.svc_col, st_reg.p1.svc_idx}] <=
            svc_oct[{st_reg.p1.svc_col, st_reg.p1.svc_idx}] + OCT_W'(st_reg.p1.len); // RL21
      end
      if (st_reg.p1.port_upd) begin
         pc_frm[{st_reg.p1.port, st_reg.p1.svc_col, st_reg.p1.prio}] <=
            pc_frm[{st_reg.p1.port, st_reg.p1.svc_col, st_reg.p1.prio}] + FRM_W'(1); // RL1
         pc_oct[{st_reg.p1.port, st_reg.p1.svc_col, st_reg.p1.prio}] <=
            pc_oct[{st_reg.p1.port, st_reg.p1.svc_col, st_reg.p1.prio}]
            + OCT_W'(st_reg.p1.len); // RL21
      end
      if (st_reg.p1.abort_upd) begin
         ab_frm[st_reg.p1.port] <= ab_frm[st_reg.p1.port] + FRM_W'(1); // RL12
         ab_oct[st_reg.p1.port] <= ab_oct[st_reg.p1.port] + OCT_W'(st_reg.p1.len);
      end
   end

   // Read back sees the count before any update in the same cycle
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         rd_v_reg <= 1'b0;
         rd_f_reg <= '0;
         rd_o_reg <= '0;
      end else begin
         rd_v_reg <= cnt_rd;
         case (cnt_rd_kind)
            CNT_SVC: begin
               rd_f_reg <= svc_frm[cnt_rd_addr];
               rd_o_reg <= svc_oct[cnt_rd_addr];
            end
            CNT_PORT: begin
               rd_f_reg <= pc_frm[cnt_rd_addr[PORT_W+PRIO_W:0]];
               rd_o_reg <= pc_oct[cnt_rd_addr[PORT_W+PRIO_W:0]];
            end
            default: begin
               rd_f_reg <= ab_frm[cnt_rd_addr[PORT_W-1:0]];
               rd_o_reg <= ab_oct[cnt_rd_addr[PORT_W-1:0]];
            end
         endcase
      end
   end

   assign cnt_rd_valid = rd_v_reg;
   assign cnt_rd_frames = rd_f_reg;
   assign cnt_rd_octets = rd_o_reg;
   assign class_key_prot = st_reg.o.prot;
   assign res_valid = st_reg.o.valid;
   assign svc_index = st_reg.o.svc_idx;
   assign svc_colour = st_reg.o.svc_col;
   assign svc_update = st_reg.o.svc_upd;
   assign port_index = {st_reg.o.port, st_reg.o.prio};
   assign port_update = st_reg.o.port_upd;
   assign abort_update = st_reg.o.abort_upd;
   assign encapsulation_id = st_reg.o.encap;
   assign oam_endpoint_index = st_reg.o.oam;
   assign map_result = st_reg.res;
   assign map_sel_a = st_reg.sel[0];
   assign map_sel_b = st_reg.sel[1];
endmodule

// ### egress_stat_pkg.sv
package egress_stat_pkg;
   localparam int IDX_W = 12;
   localparam int INGRESS_SERVICE_INDEX_W = 14;
   localparam int VID_W = 12;
   localparam int VID_KEEP = 10;
   localparam int PORT_W = 4;
   localparam int PRIO_W = 3;
   localparam int PT_W = 3;
   localparam int LEN_W = 14;
   localparam int OFS_W = 4;
   localparam int ID_W = 12;
   localparam int FRM_W = 32;
   localparam int OCT_W = 40;
   localparam int MAP_AW = 11;
   localparam int MAP_KEY_W = 6;
   localparam int MAP_BASE_W = 8;
   localparam int MAP_BASE_SHIFT = 3;
   localparam int DMAC_MC_BIT = 40;
   localparam int NUM_MAP = 4;
   localparam logic [2:0] ACT_NONE = 3'h0;
   localparam logic [2:0] ACT_INJECT = 3'h1;
   localparam logic [2:0] ACT_INJECT_X = 3'h2;
   localparam logic [2:0] ACT_QUEUE_LBK = 3'h3;
   localparam logic [2:0] ACT_EXTRACT = 3'h4;
   localparam logic [2:0] ACT_LATE_EXTRACT = 3'h5;
   localparam logic [2:0] ACT_UP_EXTRACT = 3'h6;
   localparam logic [2:0] ACT_LBK_ASSEMBLY = 3'h7;
   localparam logic [1:0] MODE_SVC = 2'h0;
   localparam logic [1:0] MODE_SVC_ONLY = 2'h1;
   localparam logic [1:0] MODE_INGRESS = 2'h2;
   localparam logic [1:0] MODE_VID = 2'h3;
   localparam logic [3:0] KEY_PCP_DEI = 4'h0;
   localparam logic [3:0] KEY_DP_COS = 4'h1;
   localparam logic [3:0] KEY_DSCP = 4'h2;
   localparam logic [3:0] KEY_TC = 4'h3;
   localparam logic [3:0] KEY_COS = 4'h4;
   localparam logic [1:0] CNT_SVC = 2'h0;
   localparam logic [1:0] CNT_PORT = 2'h1;
   localparam logic [1:0] CNT_ABORT = 2'h2;
   typedef struct packed {
      logic [2:0] tc;
      logic [5:0] dscp;
      logic dei;
      logic [2:0] pcp;
      logic oam_colour;
      logic [2:0] oam_cos;
      logic [19:0] label;
   } map_entry_s;
   typedef struct packed {
      logic valid;
      map_entry_s e;
   } map_result_s;
   typedef struct packed {
      logic [PORT_W-1:0] port;
      logic [PRIO_W-1:0] prio;
      logic [2:0] cosid;
      logic [1:0] dp;
      logic [INGRESS_SERVICE_INDEX_W-1:0] ingress_service_index;
      logic [VID_W-1:0] class_vid;
      logic pushed;
      logic [VID_W-1:0] push_vid;
      logic routed;
      logic [VID_W-1:0] routing_leg_egress_vid;
      logic [47:0] dmac;
      logic [PT_W-1:0] pt;
      logic [2:0] act;
      logic abort;
      logic abort_by_queue;
      logic protection_active_flag;
      logic [LEN_W-1:0] len;
      logic is_ip;
      logic [5:0] dscp;
      logic is_mpls;
      logic [2:0] tc;
      logic [2:0] pcp;
      logic dei;
   } frame_s;
   typedef struct packed {
      logic lookup_en;
      logic prot_sel;
      logic [IDX_W-1:0] service_counter_base;
      logic [IDX_W-1:0] service_counter_base_p;
      logic [7:0][OFS_W-1:0] service_class_offset;
      logic [ID_W-1:0] encapsulation_id;
      logic [ID_W-1:0] encapsulation_id_p;
      logic [ID_W-1:0] oam_endpoint_index;
      logic [ID_W-1:0] oam_endpoint_index_p;
      logic [NUM_MAP-1:0][3:0] map_key;
      logic [NUM_MAP-1:0][MAP_BASE_W-1:0] map_table_base;
      map_entry_s fixed;
   } action_s;
   typedef struct packed {
      logic valid;
      logic [IDX_W-1:0] svc_idx;
      logic svc_col;
      logic svc_upd;
      logic [PORT_W-1:0] port;
      logic [PRIO_W-1:0] prio;
      logic port_upd;
      logic abort_upd;
      logic [LEN_W-1:0] len;
      logic [NUM_MAP-1:0] kv;
      map_entry_s fixed;
      logic [ID_W-1:0] encap;
      logic [ID_W-1:0] oam;
      logic prot;
   } stat_s;
   typedef struct packed {
      stat_s p1;
      stat_s o;
      map_result_s [NUM_MAP-1:0] res;
      map_entry_s [1:0] sel;
   } state_s;
endpackage

// ### egress_stat_map_sva.sv
`timescale 1ns/100ps
module egress_stat_map_sva
   import egress_stat_pkg::*;
#(
   parameter int NUM_PHYS = 11
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Inputs watched
   input wire logic frame_valid,
   input wire frame_s frame,
   input wire action_s cls,
   input wire logic [1:0] stat_mode,
   input wire logic abort_count_enable,
   input wire logic cnt_rd,
   // Outputs watched
   input wire logic cnt_rd_valid,
   input wire logic class_key_prot,
   input wire logic res_valid,
   input wire logic svc_update,
   input wire logic [PORT_W+PRIO_W-1:0] port_index,
   input wire logic port_update,
   input wire logic abort_update,
   input wire map_result_s [NUM_MAP-1:0] map_result
);
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);

   AST_RES_LATENCY: assert property (frame_valid |-> ##2 res_valid)
      else $error("result missing two cycles after frame");
   AST_RES_CAUSE: assert property (res_valid |-> $past(frame_valid, 2))
      else $error("result without a frame");
   AST_PORT_EXTRACT: assert property (frame_valid && frame.act[2] |-> ##2 !port_update)
      else $error("port counted for extract action");
   AST_ABORT_NO_COUNT: assert property (frame_valid && frame.abort |-> ##2 !(port_update || svc_update))
      else $error("aborted frame counted");
   AST_PORT_INDEX: assert property (frame_valid |-> ##2 port_index == $past({frame.port, frame.prio}, 2))
      else $error("port index wrong");
   AST_ABORT_QUEUE: assert property (frame_valid && frame.abort && frame.abort_by_queue |-> ##2 abort_update)
      else $error("queue abort not counted");
   AST_ABORT_REW_OFF: assert property (frame_valid && frame.abort && !frame.abort_by_queue
      && !abort_count_enable |-> ##2 !abort_update)
      else $error("rewriter abort counted while disabled");
   AST_LATE_EXTRACT: assert property (frame_valid && frame.act == ACT_LATE_EXTRACT |-> ##2 !svc_update)
      else $error("service counted for late extract");
   AST_NON_PHYS: assert property (frame_valid && frame.port >= NUM_PHYS |-> ##2 !svc_update)
      else $error("service counted on non physical port");
   AST_PROT_KEY: assert property (frame_valid |-> ##2 class_key_prot == $past(frame.protection_active_flag, 2))
      else $error("key protection flag wrong");
   AST_MODE1_NO_SVC: assert property (frame_valid && stat_mode == MODE_SVC_ONLY && !cls.prot_sel
      && (!cls.lookup_en || cls.service_counter_base == '0) |-> ##2 !svc_update)
      else $error("mode 1 counted without egress index");
   AST_DSCP_NON_IP: assert property (frame_valid && !frame.is_ip && cls.map_key[1] == KEY_DSCP
      |-> ##2 !map_result[1].valid)
      else $error("dscp key valid on non ip frame");
   AST_CNT_READ: assert property (cnt_rd |=> cnt_rd_valid)
      else $error("counter read not answered");
endmodule

bind egress_stat_map egress_stat_map_sva #(.NUM_PHYS(NUM_PHYS)) u_egress_stat_map_sva (
   .clk_sys(clk_sys), .sys_rst(sys_rst), .frame_valid(frame_valid), .frame(frame), .cls(cls),
   .stat_mode(stat_mode), .abort_count_enable(abort_count_enable), .cnt_rd(cnt_rd),
   .cnt_rd_valid(cnt_rd_valid), .class_key_prot(class_key_prot), .res_valid(res_valid),
   .svc_update(svc_update), .port_index(port_index), .port_update(port_update),
   .abort_update(abort_update), .map_result(map_result));

// ### egress_frame_source.sv
`timescale 1ns/100ps
module egress_frame_source
   import egress_stat_pkg::*;
(
   // Clock
   input wire logic clk_sys,
   // Bench side
   input wire logic send,
   input wire frame_s frame_in,
   // Rewriter side
   output logic frame_valid,
   output frame_s frame
);
   frame_s last_reg = '0;
   always_ff @(posedge clk_sys) begin
      if (send) begin
         last_reg <= frame_in;
      end
   end
   // Idle header bus shows inverted garbage so a stale frame is never reused
   assign frame_valid = send;
   assign frame = send ? frame_in : frame_s'(~last_reg);
endmodule

// ### egress_stat_map_tb.sv
`timescale 1ns/100ps
module egress_stat_map_tb;
   import egress_stat_pkg::*;
   localparam int NPH = 11;
   typedef struct packed {
      logic [IDX_W-1:0] idx;
      logic col;
      logic su;
      logic [6:0] pidx;
      logic pu;
      logic au;
      logic [2*ID_W-1:0] ids;
      logic prot;
      map_result_s [NUM_MAP-1:0] res;
      map_entry_s sa;
      map_entry_s sb;
   } exp_s;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic send = 1'b0;
   frame_s frm_in = '0;
   logic frame_valid;
   frame_s frame;
   action_s cls = '0;
   logic [1:0] stat_mode = 2'h0;
   logic [3:0] dl_map = 4'h0;
   logic ace = 1'b0;
   logic [15:0][PT_W-1:0] xp = '0;
   logic [15:0][PT_W-1:0] ip = '0;
   logic map_wr = 1'b0;
   logic map_wr_res_b = 1'b0;
   logic [MAP_AW-1:0] map_wr_addr = '0;
   map_entry_s map_wr_data = '0;
   logic cnt_rd = 1'b0;
   logic [1:0] cnt_rd_kind = 2'h0;
   logic [IDX_W:0] cnt_rd_addr = '0;
   logic cnt_rd_valid, class_key_prot, res_valid, svc_colour, svc_update;
   logic port_update, abort_update;
   logic [FRM_W-1:0] cnt_rd_frames;
   logic [OCT_W-1:0] cnt_rd_octets;
   logic [IDX_W-1:0] svc_index;
   logic [PORT_W+PRIO_W-1:0] port_index;
   logic [ID_W-1:0] encapsulation_id, oam_endpoint_index;
   map_result_s [NUM_MAP-1:0] map_result;
   map_entry_s map_sel_a, map_sel_b;
   map_entry_s mem [2][2048];
   exp_s expq[$];
   int num_errors = 0;
   int compares = 0;
   logic rd_q = 1'b0;
   logic [31:0] seed = 32'hF;

   egress_frame_source u_egress_frame_source (.clk_sys(clk_sys), .send(send), .frame_in(frm_in),
      .frame_valid(frame_valid), .frame(frame));
   egress_stat_map u_egress_stat_map (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .frame_valid(frame_valid), .frame(frame), .cls(cls), .stat_mode(stat_mode),
      .drop_level_colour_map(dl_map), .abort_count_enable(ace), .extract_count_point(xp),
      .inject_count_point(ip), .map_wr(map_wr), .map_wr_res_b(map_wr_res_b),
      .map_wr_addr(map_wr_addr), .map_wr_data(map_wr_data), .cnt_rd(cnt_rd),
      .cnt_rd_kind(cnt_rd_kind), .cnt_rd_addr(cnt_rd_addr), .cnt_rd_valid(cnt_rd_valid),
      .cnt_rd_frames(cnt_rd_frames), .cnt_rd_octets(cnt_rd_octets),
      .class_key_prot(class_key_prot), .res_valid(res_valid), .svc_index(svc_index),
      .svc_colour(svc_colour), .svc_update(svc_update), .port_index(port_index),
      .port_update(port_update), .abort_update(abort_update),
      .encapsulation_id(encapsulation_id), .oam_endpoint_index(oam_endpoint_index),
      .map_result(map_result), .map_sel_a(map_sel_a), .map_sel_b(map_sel_b));

   initial begin
      forever #2.5 clk_sys = ~clk_sys;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic get_rnd(output logic [255:0] r);
      r = '0;
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         r = {r[223:0], seed};
      end
   endtask

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic final_report();
      $display("Comparisons %0d, errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Random frame and action, expected results worked out here
   task automatic send_frame();
      logic [255:0] r;
      frame_s f;
      action_s c;
      exp_s e;
      logic [IDX_W-1:0] base;
      logic [VID_W-1:0] vid;
      logic sw, ok;
      logic [5:0] key;
      get_rnd(r);
      f = frame_s'(r[$bits(frame_s)-1:0]);
      get_rnd(r);
      c = action_s'(r[$bits(action_s)-1:0]);
      if (r[255]) c.service_counter_base = '0;
      if (r[254]) c.service_counter_base_p = '0;
      e = '0;
      sw = c.prot_sel && f.protection_active_flag;
      base = sw ? c.service_counter_base_p : c.service_counter_base;
      e.ids = sw ? {c.encapsulation_id_p, c.oam_endpoint_index_p}
                 : {c.encapsulation_id, c.oam_endpoint_index};
      e.prot = f.protection_active_flag;
      ok = 1'b1;
      e.col = stat_mode[1] ? f.dmac[DMAC_MC_BIT] : dl_map[f.dp];
      vid = f.routed ? f.routing_leg_egress_vid : (f.pushed ? f.push_vid : f.class_vid);
      if (stat_mode == MODE_VID) begin
         e.idx = IDX_W'(vid[VID_KEEP-1:0]);
      end else if (!stat_mode[1] && c.lookup_en && base != '0) begin
         e.idx = base + IDX_W'(c.service_class_offset[f.cosid]);
      end else begin
         e.idx = f.ingress_service_index[IDX_W-1:0];
         ok = stat_mode != MODE_SVC_ONLY;
      end
      if (f.act inside {ACT_EXTRACT, ACT_UP_EXTRACT, ACT_LBK_ASSEMBLY}) ok &= f.pt >= xp[f.port];
      if (f.act inside {ACT_INJECT, ACT_INJECT_X, ACT_QUEUE_LBK}) ok &= f.pt <= ip[f.port];
      e.su = ok && f.port < NPH && !f.abort && f.act != ACT_LATE_EXTRACT;
      e.pidx = {f.port, f.prio};
      e.pu = !f.abort && !f.act[2];
      e.au = f.abort && (f.abort_by_queue || ace);
      for (int t = 0; t < NUM_MAP; t++) begin
         case (c.map_key[t])
            KEY_PCP_DEI: key = {2'h0, f.dei, f.pcp};
            KEY_DP_COS: key = {1'h0, f.dp, f.cosid};
            KEY_DSCP: key = f.dscp;
            KEY_TC: key = {3'h0, f.tc};
            default: key = {3'h0, f.cosid};
         endcase
         e.res[t].valid = c.map_key[t] <= KEY_COS && (c.map_key[t] != KEY_DSCP || f.is_ip)
            && (c.map_key[t] != KEY_TC || f.is_mpls);
         e.res[t].e = mem[t / 2][11'((int'(c.map_table_base[t]) << MAP_BASE_SHIFT) + key)];
      end
      e.sa = e.res[1].valid ? e.res[1].e : (e.res[0].valid ? e.res[0].e : c.fixed);
      e.sb = e.res[3].valid ? e.res[3].e : (e.res[2].valid ? e.res[2].e : c.fixed);
      frm_in <= f;
      cls <= c;
      send <= 1'b1;
      cnt_rd <= r[253];
      cnt_rd_kind <= r[252] ? 2'h2 : {1'b0, r[251]};
      cnt_rd_addr <= r[252] ? {9'h0, r[3:0]} : (r[251] ? {5'h0, r[7:0]} : r[12:0]);
      expq.push_back(e);
   endtask

   always @(negedge clk_sys) begin
      exp_s e;
      // A read taken at one edge must be answered at the next
      check(cnt_rd_valid, rd_q);
      rd_q = cnt_rd;
      if (res_valid === 1'b1) begin
         check(expq.size() > 0, 1'b1);
         if (expq.size() > 0) begin
            e = expq.pop_front();
            check(svc_index, e.idx);
            check(svc_colour, e.col);
            check(svc_update, e.su);
            check(port_index, e.pidx);
            check({port_update, abort_update}, {e.pu, e.au});
            check({encapsulation_id, oam_endpoint_index}, e.ids);
            check(class_key_prot, e.prot);
            for (int t = 0; t < NUM_MAP; t++) begin
               check(map_result[t].valid, e.res[t].valid);
               if (e.res[t].valid) check(map_result[t].e, e.res[t].e);
            end
            check({map_sel_a, map_sel_b}, {e.sa, e.sb});
         end
      end
   end

   // Bound well above the roughly 4,400 cycles the sequence needs
   initial begin
      #100000;
      num_errors++;
      final_report();
   end

   initial begin
      logic [255:0] r;
      repeat (5) @(posedge clk_sys);
      sys_rst <= 1'b0;
      for (int k = 0; k < 4096; k++) begin
         @(posedge clk_sys);
         get_rnd(r);
         map_wr <= 1'b1;
         map_wr_res_b <= k[11];
         map_wr_addr <= k[10:0];
         map_wr_data <= map_entry_s'(r[37:0]);
         mem[k / 2048][k % 2048] = map_entry_s'(r[37:0]);
      end
      @(posedge clk_sys);
      map_wr <= 1'b0;
      for (int m = 0; m < 4; m++) begin
         get_rnd(r);
         stat_mode <= m[1:0];
         dl_map <= r[3:0];
         ace <= m[0];
         xp <= r[47:0];
         ip <= r[95:48];
         @(posedge clk_sys);
         for (int k = 0; k < 64; k++) begin
            @(posedge clk_sys);
            send_frame();
         end
         @(posedge clk_sys);
         send <= 1'b0;
         cnt_rd <= 1'b0;
         repeat (4) @(posedge clk_sys);
      end
      check(expq.size(), 0);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      #1;
      check({res_valid, svc_update, port_update, abort_update, cnt_rd_valid}, 5'h0);
      final_report();
   end
endmodule
